// >>> logic/aapc_top.sv
// Access control word of a debug access port bridging APB4 slave accesses to an APB4 master.
// Assumes both APB sides run on clk_i; the two enable inputs are asynchronous pins.
`timescale 1ns/100ps
`include "aapc_cfg.svh"

// How it works
// - Protection field at 30:28 drives master pprot, reset value 3.
// - Master transfer only with port enable and (secure enable or prot bit 1).
// - Bit 23 reads one when both enable inputs are high.
// - Secure transfers blocked without secure enable; non-secure and internal accesses proceed.
// - With bit 17 set, a memory error stops later memory accesses until the next control word write.
// - Bit 16 clear reports master errors upstream; set hides them.
// - Bits 15:12 read zero and ignore writes.
// - Mode field 11:8 resets to zero, normal operation.
// - Bit 7 reads one while a master transfer is in progress.
// - Bit 6 follows port enable; clear blocks every master transfer.
// - Field 5:4 selects no increment or single increment; 2 and 3 reserved.
// - Address advances only after an error-free, unaborted transfer.
// - Size field fixed at 2; only 32-bit word transfers.
// - Bits 31, 27:24, 22:18 and 3 read zero; software preserves them.
// - A transfer address register holds the current master address.
// - Data register write starts master write; read starts master read, returns data.
// - Banked access uses address 31:4 from register, 3:0 from offset.
// - Direct access uses address 31:10 from register, 9:0 from offset.
module aapc_top (
  input  wire logic                    clk_i,
  input  wire logic                    rst_i,
  // APB4 slave side
  input  wire logic                    psel_i,
  input  wire logic                    penable_i,
  input  wire logic                    pwrite_i,
  input  wire logic [`AAPC_SLV_AW-1:0] paddr_i,
  input  wire logic [31:0]             pwdata_i,
  output logic                         pready_o,
  output logic      [31:0]             prdata_o,
  output logic                         pslverr_o,
  // Authentication pins
  input  wire logic                    port_enable_in_i,
  input  wire logic                    secure_enable_in_i,
  // APB4 master side
  output logic                         psel_m_o,
  output logic                         penable_m_o,
  output logic                         pwrite_m_o,
  output logic      [31:0]             paddr_m_o,
  output logic      [31:0]             pwdata_m_o,
  output logic      [3:0]              pstrb_m_o,
  output logic      [2:0]              pprot_m_o,
  input  wire logic [31:0]             prdata_m_i,
  input  wire logic                    pready_m_i,
  input  wire logic                    pslverr_m_i
);
  import aapc_pkg::*;

  // Classify a slave address
  function automatic aapc_kind_type decode_kind(input logic [`AAPC_SLV_AW-1:0] a);
    if (a < `AAPC_OFF_DIR_TOP) begin
      decode_kind = KIND_DIRECT;
    end else if (a == `AAPC_OFF_DATA) begin
      decode_kind = KIND_DATA;
    end else if ((a & `AAPC_OFF_BD_MASK) == `AAPC_OFF_BD_BASE) begin
      decode_kind = KIND_BD;
    end else begin
      decode_kind = KIND_INT;
    end
  endfunction : decode_kind

  aapc_state_type state_q, state_d;
  aapc_kind_type  kind, kind_q, kind_d;
  logic           en_meta_q, en_sync_q, sec_meta_q, sec_sync_q;
  logic [2:0]     prot_q, prot_d;
  logic           stop_q, stop_d, supp_q, supp_d, err_stop_q, err_stop_d;
  logic [3:0]     mode_q, mode_d;
  logic [1:0]     inc_q, inc_d;
  logic [31:0]    xaddr_q, xaddr_d, maddr, ctrl_rd;
  logic           busy_q, busy_d;
  logic           pready_q, pready_d, pslverr_q, pslverr_d;
  logic [31:0]    prdata_q, prdata_d;
  logic           psel_m_q, psel_m_d, penable_m_q, penable_m_d, pwrite_m_q, pwrite_m_d;
  logic [31:0]    paddr_m_q, paddr_m_d, pwdata_m_q, pwdata_m_d;
  logic [3:0]     pstrb_m_q, pstrb_m_d;
  logic           acc, allowed;

  // Two-stage synchronisers for the enable pins
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      en_meta_q  <= 1'b0;
      en_sync_q  <= 1'b0;
      sec_meta_q <= 1'b0;
      sec_sync_q <= 1'b0;
    end else begin
      en_meta_q  <= port_enable_in_i;
      en_sync_q  <= en_meta_q;
      sec_meta_q <= secure_enable_in_i;
      sec_sync_q <= sec_meta_q;
    end
  end

  // Access phase of a new slave request and the gate on memory traffic
  assign kind    = decode_kind(paddr_i);
  assign acc     = psel_i & penable_i & ~pready_q & (state_q == ST_IDLE);
  assign allowed = en_sync_q & (sec_sync_q | prot_q[`AAPC_PROT_NS]) & ~err_stop_q;

  // Master address for the request in hand
  aapc_addr_mux u_addr_mux (
    .kind_i   (kind),
    .xaddr_i  (xaddr_q),
    .offset_i (paddr_i[9:0]),
    .addr_o   (maddr)
  );

  // Read view of the control word; unlisted bits stay zero
  always_comb begin
    ctrl_rd = 32'h0000_0000;
    ctrl_rd[`AAPC_PROT_HI:`AAPC_PROT_LO] = prot_q;
    ctrl_rd[`AAPC_SDEV_BIT]              = en_sync_q & sec_sync_q;
    ctrl_rd[`AAPC_STOP_BIT]              = stop_q;
    ctrl_rd[`AAPC_SUPP_BIT]              = supp_q;
    ctrl_rd[`AAPC_MODE_HI:`AAPC_MODE_LO] = mode_q;
    ctrl_rd[`AAPC_TIP_BIT]               = busy_q;
    ctrl_rd[`AAPC_DEVEN_BIT]             = en_sync_q;
    ctrl_rd[`AAPC_INC_HI:`AAPC_INC_LO]   = inc_q;
    ctrl_rd[`AAPC_SIZE_HI:`AAPC_SIZE_LO] = `AAPC_SIZE_WORD;
  end

  // Sequencer: register accesses, master transfers and responses
  always_comb begin
    state_d     = state_q;
    kind_d      = kind_q;
    prot_d      = prot_q;
    stop_d      = stop_q;
    supp_d      = supp_q;
    mode_d      = mode_q;
    inc_d       = inc_q;
    xaddr_d     = xaddr_q;
    err_stop_d  = err_stop_q;
    busy_d      = busy_q;
    pready_d    = 1'b0;
    pslverr_d   = 1'b0;
    prdata_d    = prdata_q;
    psel_m_d    = psel_m_q;
    penable_m_d = penable_m_q;
    pwrite_m_d  = pwrite_m_q;
    paddr_m_d   = paddr_m_q;
    pwdata_m_d  = pwdata_m_q;
    pstrb_m_d   = pstrb_m_q;
    unique case (state_q)
      ST_IDLE: begin
        if (acc && kind != KIND_INT) begin
          if (allowed) begin
            state_d    = ST_MSETUP;
            kind_d     = kind;
            psel_m_d   = 1'b1;
            pwrite_m_d = pwrite_i;
            paddr_m_d  = maddr;
            pwdata_m_d = pwdata_i;
            pstrb_m_d  = pwrite_i ? `AAPC_STRB_ALL : 4'h0;
            busy_d     = 1'b1;
          end else begin
            state_d   = ST_DONE;
            pready_d  = 1'b1;
            pslverr_d = ~supp_q;
            prdata_d  = 32'h0000_0000;
          end
        end else if (acc) begin
          state_d  = ST_DONE;
          pready_d = 1'b1;
          prdata_d = 32'h0000_0000;
          if (!pwrite_i && paddr_i == `AAPC_OFF_CTRL) begin
            prdata_d = ctrl_rd;
          end else if (!pwrite_i && paddr_i == `AAPC_OFF_XADDR) begin
            prdata_d = xaddr_q;
          end
          if (pwrite_i && paddr_i == `AAPC_OFF_CTRL) begin
            prot_d     = pwdata_i[`AAPC_PROT_HI:`AAPC_PROT_LO];
            stop_d     = pwdata_i[`AAPC_STOP_BIT];
            supp_d     = pwdata_i[`AAPC_SUPP_BIT];
            mode_d     = pwdata_i[`AAPC_MODE_HI:`AAPC_MODE_LO];
            inc_d      = pwdata_i[`AAPC_INC_HI:`AAPC_INC_LO];
            err_stop_d = 1'b0;
          end else if (pwrite_i && paddr_i == `AAPC_OFF_XADDR) begin
            xaddr_d = pwdata_i;
          end
        end
      end
      ST_MSETUP: begin
        penable_m_d = 1'b1;
        state_d     = ST_MACCESS;
      end
      ST_MACCESS: begin
        if (pready_m_i) begin
          state_d     = ST_DONE;
          psel_m_d    = 1'b0;
          penable_m_d = 1'b0;
          busy_d      = 1'b0;
          pready_d    = 1'b1;
          pslverr_d   = pslverr_m_i & ~supp_q;
          prdata_d    = pwrite_m_q ? 32'h0000_0000 : prdata_m_i;
          if (pslverr_m_i && stop_q) begin
            err_stop_d = 1'b1;
          end
          if (!pslverr_m_i && kind_q == KIND_DATA && inc_q == `AAPC_INC_SINGLE) begin
            xaddr_d = xaddr_q + `AAPC_WORD_STEP;
          end
        end
      end
      ST_DONE: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // Sequencer registers
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_q     <= ST_IDLE;
      kind_q      <= KIND_INT;
      prot_q      <= `AAPC_PROT_RST;
      stop_q      <= 1'b0;
      supp_q      <= 1'b0;
      mode_q      <= `AAPC_MODE_RST;
      inc_q       <= `AAPC_INC_RST;
      xaddr_q     <= 32'h0000_0000;
      err_stop_q  <= 1'b0;
      busy_q      <= 1'b0;
      pready_q    <= 1'b0;
      pslverr_q   <= 1'b0;
      prdata_q    <= 32'h0000_0000;
      psel_m_q    <= 1'b0;
      penable_m_q <= 1'b0;
      pwrite_m_q  <= 1'b0;
      paddr_m_q   <= 32'h0000_0000;
      pwdata_m_q  <= 32'h0000_0000;
      pstrb_m_q   <= 4'h0;
    end else begin
      state_q     <= state_d;
      kind_q      <= kind_d;
      prot_q      <= prot_d;
      stop_q      <= stop_d;
      supp_q      <= supp_d;
      mode_q      <= mode_d;
      inc_q       <= inc_d;
      xaddr_q     <= xaddr_d;
      err_stop_q  <= err_stop_d;
      busy_q      <= busy_d;
      pready_q    <= pready_d;
      pslverr_q   <= pslverr_d;
      prdata_q    <= prdata_d;
      psel_m_q    <= psel_m_d;
      penable_m_q <= penable_m_d;
      pwrite_m_q  <= pwrite_m_d;
      paddr_m_q   <= paddr_m_d;
      pwdata_m_q  <= pwdata_m_d;
      pstrb_m_q   <= pstrb_m_d;
    end
  end

  // Outputs straight from flip-flops
  assign pready_o    = pready_q;
  assign prdata_o    = prdata_q;
  assign pslverr_o   = pslverr_q;
  assign psel_m_o    = psel_m_q;
  assign penable_m_o = penable_m_q;
  assign pwrite_m_o  = pwrite_m_q;
  assign paddr_m_o   = paddr_m_q;
  assign pwdata_m_o  = pwdata_m_q;
  assign pstrb_m_o   = pstrb_m_q;
  assign pprot_m_o   = prot_q;

  // Checks on the block's own behaviour
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // A control word write reaches pprot one cycle later
  property p_prot_drive;
    acc && kind == KIND_INT && pwrite_i && paddr_i == `AAPC_OFF_CTRL
      |=> pprot_m_o == $past(pwdata_i[`AAPC_PROT_HI:`AAPC_PROT_LO]);
  endproperty
  a_prot_drive: assert property (p_prot_drive)
    else $error("pprot does not follow the written protection field");

  // A master transfer starts only when the enables permit it
  property p_gate;
    $rose(psel_m_o) |-> $past(en_sync_q) && ($past(sec_sync_q) || $past(prot_q[1]));
  endproperty
  a_gate: assert property (p_gate)
    else $error("master transfer started without permission");

  // A control word read returns enable status as the synchronised pins stood
  property p_sdev;
    acc && !pwrite_i && paddr_i == `AAPC_OFF_CTRL
      |=> prdata_o[`AAPC_SDEV_BIT] == $past(en_sync_q && sec_sync_q)
      && prdata_o[`AAPC_DEVEN_BIT] == $past(en_sync_q);
  endproperty
  a_sdev: assert property (p_sdev)
    else $error("enable status bits disagree with the synchronised pins");

  // A stopped port issues no master transfer
  property p_stop_on_error;
    $rose(psel_m_o) |-> !$past(err_stop_q);
  endproperty
  a_stop_on_error: assert property (p_stop_on_error)
    else $error("master transfer after a stop-on-error fault");

  // Master errors answer upstream one cycle later unless suppressed
  property p_errpass;
    state_q == ST_MACCESS && pready_m_i |=> pready_o && pslverr_o == $past(pslverr_m_i && !supp_q);
  endproperty
  a_errpass: assert property (p_errpass)
    else $error("master error response not passed as configured");

  // A control word read returns reserved bits as zero and size as word
  property p_reserved;
    acc && !pwrite_i && paddr_i == `AAPC_OFF_CTRL
      |=> (prdata_o & 32'h8F7C_F008) == 32'h0000_0000 && prdata_o[2:0] == `AAPC_SIZE_WORD;
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("reserved control word bits not zero");

  // Progress flag and master select agree
  property p_busy;
    busy_q == psel_m_o && ctrl_rd[`AAPC_TIP_BIT] == busy_q;
  endproperty
  a_busy: assert property (p_busy)
    else $error("progress flag disagrees with the master select");

  // Address advances by one word only after a clean incrementing transfer
  property p_inc;
    state_q == ST_MACCESS && pready_m_i && !pslverr_m_i && kind_q == KIND_DATA
      && inc_q == `AAPC_INC_SINGLE |=> xaddr_q == $past(xaddr_q) + `AAPC_WORD_STEP;
  endproperty
  a_inc: assert property (p_inc)
    else $error("transfer address did not advance by one word");

  // Writes carry all byte strobes, reads none
  property p_strb;
    psel_m_o |-> pstrb_m_o == (pwrite_m_o ? `AAPC_STRB_ALL : 4'h0);
  endproperty
  a_strb: assert property (p_strb)
    else $error("master strobes are not a full word");

endmodule : aapc_top

// >>> logic/aapc_cfg.svh
// Offsets, field positions, reset values and fixed codes of the access control word.
// Assumes inclusion by bare name from the package and the design files.
`ifndef AAPC_CFG_SVH
`define AAPC_CFG_SVH

// Slave address width and register offsets
`define AAPC_SLV_AW       13
`define AAPC_OFF_CTRL     13'h0D00
`define AAPC_OFF_XADDR    13'h0D04
`define AAPC_OFF_DATA     13'h0D0C
`define AAPC_OFF_BD_BASE  13'h0D10
`define AAPC_OFF_BD_MASK  13'h1FF0
`define AAPC_OFF_DIR_TOP  13'h0400

// Control word field positions
`define AAPC_PROT_HI      30
`define AAPC_PROT_LO      28
`define AAPC_PROT_NS      1
`define AAPC_SDEV_BIT     23
`define AAPC_STOP_BIT     17
`define AAPC_SUPP_BIT     16
`define AAPC_MODE_HI      11
`define AAPC_MODE_LO      8
`define AAPC_TIP_BIT      7
`define AAPC_DEVEN_BIT    6
`define AAPC_INC_HI       5
`define AAPC_INC_LO       4
`define AAPC_SIZE_HI      2
`define AAPC_SIZE_LO      0

// Reset values and fixed codes
`define AAPC_PROT_RST     3'h3
`define AAPC_MODE_RST     4'h0
`define AAPC_INC_RST      2'h0
`define AAPC_INC_SINGLE   2'h1
`define AAPC_SIZE_WORD    3'h2
`define AAPC_WORD_STEP    32'h0000_0004
`define AAPC_STRB_ALL     4'hF

`endif

// >>> logic/aapc_pkg.sv
// Types shared by the access control word design files.
// Assumes the constants header is on the include path.
`include "aapc_cfg.svh"

package aapc_pkg;

  // Sequencer states, one-hot
  typedef enum logic [3:0] {
    ST_IDLE    = 4'b0001,
    ST_MSETUP  = 4'b0010,
    ST_MACCESS = 4'b0100,
    ST_DONE    = 4'b1000
  } aapc_state_type;

  // What a slave access addresses
  typedef enum logic [1:0] {
    KIND_INT    = 2'h0,
    KIND_DATA   = 2'h1,
    KIND_BD     = 2'h2,
    KIND_DIRECT = 2'h3
  } aapc_kind_type;

endpackage : aapc_pkg

// >>> logic/aapc_addr_mux.sv
// Master address composer: merges the transfer address with the register offset.
// Assumes a kind code and slave offset from the same clock domain; purely combinational.
`timescale 1ns/100ps

module aapc_addr_mux (
  input  wire aapc_pkg::aapc_kind_type kind_i,
  input  wire logic [31:0]             xaddr_i,
  input  wire logic [9:0]              offset_i,
  output logic      [31:0]             addr_o
);
  import aapc_pkg::*;

  // Select how many low bits the offset supplies
  always_comb begin
    unique case (kind_i)
      KIND_BD:     addr_o = {xaddr_i[31:4], offset_i[3:0]};
      KIND_DIRECT: addr_o = {xaddr_i[31:10], offset_i[9:0]};
      default:     addr_o = xaddr_i;
    endcase
  end

endmodule : aapc_addr_mux

// >>> testbench/aapc_mem_model.sv
// APB4 memory model standing on the master side of the access port.
// Assumes requests on clk_i; wait states and one faulting address are set by the bench.
`timescale 1ns/100ps

module aapc_mem_model (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [31:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  input  wire logic [1:0]  wait_i,
  input  wire logic [31:0] err_addr_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  output logic      [31:0] last_addr_o,
  output logic      [7:0]  n_xfer_o
);
  logic [31:0] mem_q [0:63];
  logic [1:0]  wcnt_q;
  logic [31:0] rd_last_q;

  // Ready after the programmed wait states; error only on the faulting address
  assign pready_o  = psel_i && penable_i && (wcnt_q == wait_i);
  assign pslverr_o = pready_o && (paddr_i == err_addr_i);
  // Outside the answer cycle the data lines show the inverse of the last word
  assign prdata_o  = pready_o ? mem_q[paddr_i[7:2]] : ~rd_last_q;

  // Wait counter, storage and transfer log
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wcnt_q      <= 2'h0;
      rd_last_q   <= 32'h0000_0000;
      last_addr_o <= 32'h0000_0000;
      n_xfer_o    <= 8'h00;
    end else begin
      wcnt_q <= (psel_i && penable_i && !pready_o) ? wcnt_q + 2'h1 : 2'h0;
      if (pready_o) begin
        rd_last_q   <= prdata_o;
        last_addr_o <= paddr_i;
        n_xfer_o    <= n_xfer_o + 8'h01;
        if (pwrite_i && !pslverr_o) begin
          mem_q[paddr_i[7:2]] <= pwdata_i;
        end
      end
    end
  end
endmodule : aapc_mem_model

// >>> testbench/aapc_top_tb.sv
// Self-checking bench for the access control word and its APB4 bridge.
// Assumes the design files and the memory model are compiled first.
`timescale 1ns/100ps
`include "aapc_cfg.svh"

module aapc_top_tb;
  import aapc_pkg::*;
  logic        clk_i, rst_i, psel_i, penable_i, pwrite_i, pe_i, se_i;
  logic [12:0] paddr_i;
  logic [31:0] pwdata_i, prdata_o, paddr_m, pwdata_m, prdata_m, err_addr, last_addr;
  logic        pready_o, pslverr_o, psel_m, penable_m, pwrite_m, pready_m, pslverr_m;
  logic [3:0]  pstrb_m;
  logic [2:0]  pprot_m;
  logic [1:0]  wait_c;
  logic [7:0]  n_xfer, n;
  int          n_fail, num_checks, cycles;

  aapc_top u_aapc_top (.clk_i(clk_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pready_o(pready_o),
    .prdata_o(prdata_o), .pslverr_o(pslverr_o), .port_enable_in_i(pe_i),
    .secure_enable_in_i(se_i), .psel_m_o(psel_m), .penable_m_o(penable_m),
    .pwrite_m_o(pwrite_m), .paddr_m_o(paddr_m), .pwdata_m_o(pwdata_m), .pstrb_m_o(pstrb_m),
    .pprot_m_o(pprot_m), .prdata_m_i(prdata_m), .pready_m_i(pready_m),
    .pslverr_m_i(pslverr_m));

  aapc_mem_model u_aapc_mem_model (.clk_i(clk_i), .rst_i(rst_i), .psel_i(psel_m),
    .penable_i(penable_m), .pwrite_i(pwrite_m), .paddr_i(paddr_m), .pwdata_i(pwdata_m),
    .wait_i(wait_c), .err_addr_i(err_addr), .prdata_o(prdata_m), .pready_o(pready_m),
    .pslverr_o(pslverr_m), .last_addr_o(last_addr), .n_xfer_o(n_xfer));

  // Clock and cycle ceiling
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      end_of_test();
    end
  end
  // Master writes always carry all four strobes
  always @(negedge clk_i) begin
    if (psel_m === 1'b1 && penable_m === 1'b1 && pwrite_m === 1'b1) chk(pstrb_m, 4'hF);
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // One slave access: setup, access, hold until ready is sampled, then release
  task automatic xfer(input logic wr, input logic [12:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
    @(negedge clk_i);
    psel_i   = 1'b1;
    pwrite_i = wr;
    paddr_i  = a;
    pwdata_i = d;
    @(negedge clk_i);
    penable_i = 1'b1;
    do @(negedge clk_i); while (pready_o !== 1'b1);
    r = prdata_o;
    e = pslverr_o;
    @(negedge clk_i);
    psel_i    = 1'b0;
    penable_i = 1'b0;
  endtask : xfer

  task automatic wr(input logic [12:0] a, input logic [31:0] d, input logic ee);
    logic [31:0] r;
    logic        e;
    xfer(1'b1, a, d, r, e);
    chk(e, ee);
  endtask : wr

  task automatic rd(input logic [12:0] a, input logic [31:0] x, input logic ee);
    logic [31:0] r;
    logic        e;
    xfer(1'b0, a, 32'h0000_0000, r, e);
    chk(r, x);
    chk(e, ee);
  endtask : rd

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : end_of_test

  // Main sequence
  initial begin
    rst_i = 1'b1; psel_i = 1'b0; penable_i = 1'b0; pwrite_i = 1'b0;
    paddr_i = 13'h0000; pwdata_i = 32'h0000_0000; pe_i = 1'b1; se_i = 1'b1;
    wait_c = 2'h0; err_addr = 32'hFFFF_FFF0;
    repeat (2) @(negedge clk_i);
    rst_i = 1'b0;
    repeat (3) @(negedge clk_i);
    chk(pprot_m, 3'h3);
    rd(`AAPC_OFF_CTRL, 32'h3080_0042, 1'b0);
    $display("test reset values done");
    wr(`AAPC_OFF_CTRL, 32'h7003_FFF7, 1'b0);
    rd(`AAPC_OFF_CTRL, 32'h7083_0F72, 1'b0);
    chk(pprot_m, 3'h7);
    wr(`AAPC_OFF_CTRL, 32'h2000_0010, 1'b0);
    $display("test field access done");
    wr(`AAPC_OFF_XADDR, 32'h0000_0100, 1'b0);
    wr(`AAPC_OFF_DATA, 32'h1111_1111, 1'b0);
    chk(last_addr, 32'h0000_0100);
    wr(`AAPC_OFF_DATA, 32'h2222_2222, 1'b0);
    chk(last_addr, 32'h0000_0104);
    wr(`AAPC_OFF_XADDR, 32'h0000_0100, 1'b0);
    rd(`AAPC_OFF_DATA, 32'h1111_1111, 1'b0);
    wait_c = 2'h3;
    rd(`AAPC_OFF_DATA, 32'h2222_2222, 1'b0);
    wait_c = 2'h0;
    rd(`AAPC_OFF_XADDR, 32'h0000_0108, 1'b0);
    $display("test data register done");
    wr(`AAPC_OFF_XADDR, 32'h1234_5674, 1'b0);
    wr(13'h0D18, 32'h3333_3333, 1'b0);
    chk(last_addr, 32'h1234_5678);
    wr(13'h03FC, 32'h4444_4444, 1'b0);
    chk(last_addr, 32'h1234_57FC);
    rd(`AAPC_OFF_XADDR, 32'h1234_5674, 1'b0);
    $display("test banked and direct done");
    wr(`AAPC_OFF_XADDR, 32'h0000_0200, 1'b0);
    err_addr = 32'h0000_0200;
    wr(`AAPC_OFF_DATA, 32'h5555_5555, 1'b1);
    rd(`AAPC_OFF_XADDR, 32'h0000_0200, 1'b0);
    wr(`AAPC_OFF_CTRL, 32'h2001_0010, 1'b0);
    wr(`AAPC_OFF_DATA, 32'h5555_5555, 1'b0);
    rd(`AAPC_OFF_XADDR, 32'h0000_0200, 1'b0);
    wr(`AAPC_OFF_CTRL, 32'h2002_0010, 1'b0);
    wr(`AAPC_OFF_DATA, 32'h5555_5555, 1'b1);
    n = n_xfer;
    wr(`AAPC_OFF_XADDR, 32'h0000_0300, 1'b0);
    wr(`AAPC_OFF_DATA, 32'h6666_6666, 1'b1);
    chk(n_xfer, n);
    wr(`AAPC_OFF_CTRL, 32'h2000_0010, 1'b0);
    wr(`AAPC_OFF_DATA, 32'h6666_6666, 1'b0);
    chk(n_xfer, n + 8'h01);
    $display("test error handling done");
    pe_i = 1'b0;
    repeat (4) @(negedge clk_i);
    rd(`AAPC_OFF_CTRL, 32'h2000_0012, 1'b0);
    n = n_xfer;
    wr(`AAPC_OFF_DATA, 32'h7777_7777, 1'b1);
    chk(n_xfer, n);
    pe_i = 1'b1;
    se_i = 1'b0;
    repeat (4) @(negedge clk_i);
    wr(`AAPC_OFF_CTRL, 32'h0000_0010, 1'b0);
    rd(`AAPC_OFF_CTRL, 32'h0000_0052, 1'b0);
    wr(`AAPC_OFF_DATA, 32'h7777_7777, 1'b1);
    chk(n_xfer, n);
    wr(`AAPC_OFF_CTRL, 32'h2000_0010, 1'b0);
    wr(`AAPC_OFF_DATA, 32'h7777_7777, 1'b0);
    chk(n_xfer, n + 8'h01);
    se_i = 1'b1;
    rd(13'h0D08, 32'h0000_0000, 1'b0);
    $display("test gating done");
    end_of_test();
  end
endmodule : aapc_top_tb
